// file: meter_pkg.sv
// Package with settings layout, key strobes and timing constants for the meter panel control
// How it works
// - Menu locked out in ref, comparator, capture
// - Menu key steps 0..8 then measurement
// - Menu edits staged, applied on menu exit
// - Menu 0: off, serial, or printer
// - Menu 1: 9600 or 19200 rate
// - Menu 2: station id 0..15
// - Menu 3: peak hold off/on
// - Menu 4: threshold 0..98 step 2
// - Menu 5: delay 0..9 seconds
// - Menu 6: auto clear enable
// - Menu 7: clear time 0..90 seconds
// - Menu 8: buzzer follows alarm when enabled
// - Settings kept except peak hold
// - Ref key toggles full-scale reference mode
// - Ref mode: only light, ref keys
// - Ref tone 80 Hz or 1 Hz
// - Capture shows running max, overrange flag
// - Clear key clears held maximum
// - Capture mode: light, capture, clear keys
// - Peak hold tracks peaks, accel only
// - Peak mode: light, menu, clear keys
// - Comparator compares level, key toggles it
// - Auto clear after time below threshold
// - Clear key drops alarm, comparator stays
// - Display blinks 0.5 s while alarm
package meter_pkg;

	// ************************************************************
	// Clock and timing
	// ************************************************************
	localparam int unsigned CLK_HZ        = 20000000;
	localparam int unsigned SECOND_NS     = 1000000000;
	localparam int unsigned BLINK_NS      = 500000000;
	localparam int unsigned PEAK_SAMPLE_HZ = 51200;
	localparam int unsigned TONE_CHG_HZ   = 80;
	localparam int unsigned TONE_SRV_HZ   = 1;
	// Cycles per millisecond times milliseconds; keeps every product inside 32 bits
	localparam int unsigned SECOND_CYC    = CLK_HZ / 1000 * (SECOND_NS / 1000000);
	localparam int unsigned BLINK_CYC     = CLK_HZ / 1000 * (BLINK_NS / 1000000);
	localparam int unsigned PEAK_CYC      = CLK_HZ / PEAK_SAMPLE_HZ;
	localparam int unsigned TONE_CHG_HALF = CLK_HZ / (2 * TONE_CHG_HZ);
	localparam int unsigned TONE_SRV_HALF = CLK_HZ / (2 * TONE_SRV_HZ);

	// ************************************************************
	// Setting ranges
	// ************************************************************
	localparam int unsigned LVL_W         = 16;
	localparam logic [3:0]  MENU_LAST     = 4'h8;
	localparam logic [1:0]  PORT_OFF      = 2'h0;
	localparam logic [1:0]  PORT_SERIAL   = 2'h1;
	localparam logic [1:0]  PORT_PRINTER  = 2'h2;
	localparam logic [3:0]  ID_MAX        = 4'hF;
	localparam logic [6:0]  THR_MAX       = 7'h62;
	localparam logic [6:0]  THR_STEP      = 7'h02;
	localparam logic [3:0]  DELAY_MAX     = 4'h9;
	localparam logic [6:0]  CLR_MAX       = 7'h5A;
	localparam logic [6:0]  PCT_FULL      = 7'h64;

	typedef enum logic [1:0] {RATE_9600, RATE_19200} rate_e;

	// Persistent settings image, peak hold kept out of it
	typedef struct packed {
		logic [1:0] port_mode;
		rate_e      rate;
		logic [3:0] station_id;
		logic [6:0] thr_pct;
		logic [3:0] delay_s;
		logic       auto_clr;
		logic [6:0] clr_s;
		logic       buzz_en;
	} settings_s;

	localparam settings_s SETTINGS_RST = '{PORT_OFF, RATE_9600, 4'h0, 7'h00, 4'h0,
		1'b0, 7'h00, 1'b0};

	// Front-panel key strobes, one cycle each
	typedef struct packed {
		logic menu;
		logic up;
		logic down;
		logic ref_sig;
		logic capture;
		logic clear;
		logic comp;
	} keys_s;

endpackage

// file: sec_timer.sv
// Second-count timer used for comparator delay and auto clear
`timescale 1ns/10ps
module sec_timer
(
	// Clock and reset
	input  wire logic       core_clk_i,
	input  wire logic       rst_i,
	// Control
	input  wire logic       run_i,
	input  wire logic [6:0] secs_i,
	// Status
	output logic            done_o
);

	logic [24:0] tick_q;
	logic [6:0]  secs_q;

	// Restarts whenever run drops, so only continuous runs count
	always_ff @(posedge core_clk_i)
	begin
		if (rst_i || !run_i)
		begin
			tick_q <= '0;
			secs_q <= '0;
		end
		else if (secs_q != secs_i)
		begin
			if (tick_q == 25'(meter_pkg::SECOND_CYC - 1))
			begin
				tick_q <= '0;
				secs_q <= secs_q + 7'h01;
			end
			else
				tick_q <= tick_q + 25'h0000001;
		end
	end

	assign done_o = run_i && (secs_q == secs_i);

endmodule

// file: half_period_osc.sv
// Square wave generator with a selectable half period
`timescale 1ns/10ps
module half_period_osc
(
	// Clock and reset
	input  wire logic        core_clk_i,
	input  wire logic        rst_i,
	// Control
	input  wire logic        run_i,
	input  wire logic [23:0] half_i,
	// Output
	output logic             wave_o
);

	logic [23:0] cnt_q;

	// Free toggling while run, parked low otherwise
	always_ff @(posedge core_clk_i)
	begin
		if (rst_i || !run_i)
		begin
			cnt_q  <= '0;
			wave_o <= 1'b0;
		end
		else if (cnt_q >= half_i - 24'h000001)
		begin
			cnt_q  <= '0;
			wave_o <= !wave_o;
		end
		else
			cnt_q <= cnt_q + 24'h000001;
	end

endmodule

// file: meter_panel_ctrl.sv
// Front-panel control: menu, reference mode, max and peak hold, comparator alarm
`timescale 1ns/10ps
module meter_panel_ctrl
(
	// Clock and reset
	input  wire logic                  core_clk_i,
	input  wire logic                  rst_i,
	// Front-panel keys
	input  wire meter_pkg::keys_s      keys_i,
	// Measurement side
	input  wire logic [15:0]           level_i,
	input  wire logic [15:0]           full_scale_i,
	input  wire logic [15:0]           overload_i,
	input  wire logic                  servo_input_i,
	input  wire logic                  accel_mode_i,
	// Nonvolatile settings image
	input  wire meter_pkg::settings_s  nv_settings_i,
	input  wire logic                  nv_valid_i,
	output meter_pkg::settings_s       nv_settings_o,
	output logic                       nv_write_o,
	// Display
	output logic [3:0]                 menu_num_o,
	output logic                       menu_shown_o,
	output meter_pkg::settings_s       menu_view_o,
	output logic                       peak_en_view_o,
	output logic [15:0]                numeric_o,
	output logic                       over_flag_o,
	output logic                       blank_o,
	// Modes and outputs
	output meter_pkg::settings_s       settings_o,
	output logic                       peak_hold_o,
	output logic                       ref_mode_o,
	output logic                       capture_o,
	output logic                       comp_on_o,
	output logic                       alarm_o,
	output logic                       buzzer_o,
	output logic                       ref_tone_o,
	output logic [15:0]                steady_level_output_o
);

	// ************************************************************
	// Menu state
	// ************************************************************
	typedef enum logic [1:0] {S_MEASURE, S_MENU} view_e;

	view_e                view_q;
	logic [3:0]           menu_q;
	meter_pkg::settings_s stage_q;
	meter_pkg::settings_s live_q;
	logic                 peak_stage_q;
	logic                 peak_q;
	logic                 ref_q;
	logic                 cap_q;
	logic                 comp_q;
	logic                 alarm_q;
	logic                 loaded_q;
	logic [15:0]          max_q;
	logic [15:0]          peak_val_q;
	logic [10:0]          smp_q;
	logic [24:0]          blink_cnt_q;
	logic                 blink_q;

	logic exit_menu;
	logic enter_ok;
	logic key_menu_ok;
	logic key_clear_ok;
	logic key_comp_ok;
	logic key_cap_ok;
	logic above;
	logic delay_done;
	logic clear_done;

	// Key acceptance per active mode; light and power never reach this block
	assign key_menu_ok  = keys_i.menu && !ref_q && !cap_q && !comp_q;
	assign enter_ok     = key_menu_ok && (view_q == S_MEASURE);
	assign key_clear_ok = keys_i.clear && !ref_q;
	assign key_cap_ok   = keys_i.capture && !ref_q && !comp_q && !peak_q
		&& view_q == S_MEASURE;
	assign key_comp_ok  = keys_i.comp && !ref_q && !cap_q && !peak_q
		&& view_q == S_MEASURE;
	assign exit_menu    = key_menu_ok && view_q == S_MENU && menu_q == meter_pkg::MENU_LAST;

	// Menu page stepping
	always_ff @(posedge core_clk_i)
	begin
		if (rst_i)
		begin
			view_q <= S_MEASURE;
			menu_q <= 4'h0;
		end
		else if (enter_ok)
		begin
			view_q <= S_MENU;
			menu_q <= 4'h0;
		end
		else if (key_menu_ok && view_q == S_MENU)
		begin
			unique case (menu_q == meter_pkg::MENU_LAST)
				1'b1: view_q <= S_MEASURE;
				1'b0: menu_q <= menu_q + 4'h1;
			endcase
		end
	end

	// Saturating step helper for numeric items
	function automatic logic [6:0] step7(input logic [6:0] v, input logic [6:0] mx,
		input logic [6:0] st, input logic up);
		if (up)
			step7 = (v + st > mx) ? v : 7'(v + st);
		else
			step7 = (v < st) ? v : 7'(v - st);
	endfunction

	// Staged edits on the shown item, copied in from live on entry
	always_ff @(posedge core_clk_i)
	begin
		if (rst_i)
		begin
			stage_q      <= meter_pkg::SETTINGS_RST;
			peak_stage_q <= 1'b0;
		end
		else if (enter_ok)
		begin
			stage_q      <= live_q;
			peak_stage_q <= peak_q;
		end
		else if (view_q == S_MENU && (keys_i.up || keys_i.down))
		begin
			unique case (menu_q)
				4'h0: stage_q.port_mode <= keys_i.up ?
					((stage_q.port_mode == meter_pkg::PORT_PRINTER) ? stage_q.port_mode
					: stage_q.port_mode + 2'h1) :
					((stage_q.port_mode == meter_pkg::PORT_OFF) ? stage_q.port_mode
					: stage_q.port_mode - 2'h1);
				4'h1: stage_q.rate <= keys_i.up ? meter_pkg::RATE_19200
					: meter_pkg::RATE_9600;
				4'h2: stage_q.station_id <= 4'(step7({3'h0, stage_q.station_id},
					{3'h0, meter_pkg::ID_MAX}, 7'h01, keys_i.up));
				4'h3: peak_stage_q <= keys_i.up;
				4'h4: stage_q.thr_pct <= step7(stage_q.thr_pct, meter_pkg::THR_MAX,
					meter_pkg::THR_STEP, keys_i.up);
				4'h5: stage_q.delay_s <= 4'(step7({3'h0, stage_q.delay_s},
					{3'h0, meter_pkg::DELAY_MAX}, 7'h01, keys_i.up));
				4'h6: stage_q.auto_clr <= keys_i.up;
				4'h7: stage_q.clr_s <= step7(stage_q.clr_s, meter_pkg::CLR_MAX,
					7'h01, keys_i.up);
				4'h8: stage_q.buzz_en <= keys_i.up;
				default: stage_q <= stage_q;
			endcase
		end
	end

	// ************************************************************
	// Live settings and retention
	// ************************************************************
	// Live copy loads from storage once after reset, then only on menu exit
	always_ff @(posedge core_clk_i)
	begin
		if (rst_i)
		begin
			live_q   <= meter_pkg::SETTINGS_RST;
			loaded_q <= 1'b0;
			peak_q   <= 1'b0;
		end
		else
		begin
			if (!loaded_q && nv_valid_i)
			begin
				live_q   <= nv_settings_i;
				loaded_q <= 1'b1;
			end
			if (exit_menu)
			begin
				live_q <= stage_q;
				peak_q <= peak_stage_q && accel_mode_i;
			end
		end
	end

	// Write strobe to storage on every apply; peak hold not part of image
	always_ff @(posedge core_clk_i)
	begin
		if (rst_i)
			nv_write_o <= 1'b0;
		else
			nv_write_o <= exit_menu;
	end
	assign nv_settings_o = live_q;

	// ************************************************************
	// Modes
	// ************************************************************
	// Mode toggles; reference mode only from plain measurement
	always_ff @(posedge core_clk_i)
	begin
		if (rst_i)
		begin
			ref_q  <= 1'b0;
			cap_q  <= 1'b0;
			comp_q <= 1'b0;
		end
		else
		begin
			if (keys_i.ref_sig && view_q == S_MEASURE && !cap_q && !comp_q && !peak_q)
				ref_q <= !ref_q;
			if (key_cap_ok)
				cap_q <= !cap_q;
			if (key_comp_ok)
				comp_q <= !comp_q;
		end
	end

	// Running maximum while capture is on
	always_ff @(posedge core_clk_i)
	begin
		if (rst_i || !cap_q || key_clear_ok)
			max_q <= '0;
		else if (level_i > max_q)
			max_q <= level_i;
	end

	// Peak sample strobe at the high sampling rate
	always_ff @(posedge core_clk_i)
	begin
		if (rst_i || smp_q == 11'(meter_pkg::PEAK_CYC - 1))
			smp_q <= '0;
		else
			smp_q <= smp_q + 11'h001;
	end

	// Highest sampled peak while peak hold is on
	always_ff @(posedge core_clk_i)
	begin
		if (rst_i || !peak_q || key_clear_ok)
			peak_val_q <= '0;
		else if (smp_q == '0 && level_i > peak_val_q)
			peak_val_q <= level_i;
	end

	// ************************************************************
	// Comparator
	// ************************************************************
	// Threshold is percent of full scale, widened to avoid overflow
	assign above = comp_q && ({16'h0000, level_i} * 32'(meter_pkg::PCT_FULL) >
		{16'h0000, full_scale_i} * {25'h0000000, live_q.thr_pct});

	sec_timer u_delay
	(
		.core_clk_i (core_clk_i),
		.rst_i      (rst_i),
		.run_i      (above && !alarm_q),
		.secs_i     ({3'h0, live_q.delay_s}),
		.done_o     (delay_done)
	);

	sec_timer u_clear
	(
		.core_clk_i (core_clk_i),
		.rst_i      (rst_i),
		.run_i      (alarm_q && !above && live_q.auto_clr),
		.secs_i     (live_q.clr_s),
		.done_o     (clear_done)
	);

	// Alarm latch; clear key and comparator off both drop it at once
	always_ff @(posedge core_clk_i)
	begin
		if (rst_i || !comp_q || key_clear_ok || key_comp_ok)
			alarm_q <= 1'b0;
		else if (delay_done)
			alarm_q <= 1'b1;
		else if (clear_done)
			alarm_q <= 1'b0;
	end

	// Blink phase for the value area
	always_ff @(posedge core_clk_i)
	begin
		if (rst_i || !alarm_q)
		begin
			blink_cnt_q <= '0;
			blink_q     <= 1'b0;
		end
		else if (blink_cnt_q == 25'(meter_pkg::BLINK_CYC - 1))
		begin
			blink_cnt_q <= '0;
			blink_q     <= !blink_q;
		end
		else
			blink_cnt_q <= blink_cnt_q + 25'h0000001;
	end

	half_period_osc u_tone
	(
		.core_clk_i (core_clk_i),
		.rst_i      (rst_i),
		.run_i      (ref_q),
		.half_i     (servo_input_i ? 24'(meter_pkg::TONE_SRV_HALF)
			: 24'(meter_pkg::TONE_CHG_HALF)),
		.wave_o     (ref_tone_o)
	);

	// ************************************************************
	// Display and outputs
	// ************************************************************
	// Numeric value follows the active hold mode
	always_ff @(posedge core_clk_i)
	begin
		if (rst_i)
		begin
			numeric_o             <= '0;
			over_flag_o           <= 1'b0;
			steady_level_output_o <= '0;
		end
		else
		begin
			numeric_o   <= cap_q ? max_q : (peak_q ? peak_val_q : level_i);
			over_flag_o <= (cap_q && max_q > overload_i)
				|| (peak_q && peak_val_q > overload_i);
			steady_level_output_o <= ref_q ? full_scale_i : level_i;
		end
	end

	assign menu_num_o     = menu_q;
	assign menu_shown_o   = (view_q == S_MENU);
	assign menu_view_o    = stage_q;
	assign peak_en_view_o = peak_stage_q;
	assign settings_o     = live_q;
	assign peak_hold_o    = peak_q;
	assign ref_mode_o     = ref_q;
	assign capture_o      = cap_q;
	assign comp_on_o      = comp_q;
	assign alarm_o        = alarm_q;
	assign blank_o        = blink_q;
	assign buzzer_o       = alarm_q && live_q.buzz_en;

	// ************************************************************
	// Checks
	// ************************************************************
	a_menu_lockout: assert property (@(posedge core_clk_i) disable iff (rst_i)
		(ref_q || cap_q || comp_q) && view_q == S_MEASURE |=> view_q == S_MEASURE)
		else $error("menu entered while locked");
	a_menu_wrap: assert property (@(posedge core_clk_i) disable iff (rst_i)
		exit_menu |=> view_q == S_MEASURE && nv_write_o)
		else $error("menu did not return after last page");
	a_apply_exit: assert property (@(posedge core_clk_i) disable iff (rst_i)
		view_q == S_MENU && !exit_menu && loaded_q |=> $stable(live_q))
		else $error("settings applied inside menu");
	a_thr_range: assert property (@(posedge core_clk_i) disable iff (rst_i)
		!stage_q.thr_pct[0] || !loaded_q)
		else $error("odd threshold staged");
	a_buzz_gate: assert property (@(posedge core_clk_i) disable iff (rst_i)
		buzzer_o |-> alarm_q && live_q.buzz_en)
		else $error("buzzer without enabled alarm");
	a_clear_alarm: assert property (@(posedge core_clk_i) disable iff (rst_i)
		key_clear_ok && comp_q && !keys_i.comp |=> !alarm_q && comp_q)
		else $error("clear key did not drop alarm");
	a_max_mono: assert property (@(posedge core_clk_i) disable iff (rst_i)
		cap_q && $past(cap_q) && !$past(key_clear_ok) |-> max_q >= $past(max_q))
		else $error("held maximum fell");
	a_zero_delay: assert property (@(posedge core_clk_i) disable iff (rst_i)
		live_q.delay_s == 4'h0 && above && !alarm_q && !key_clear_ok && !key_comp_ok
		&& !$changed(live_q) |=> alarm_q)
		else $error("zero delay alarm late");
	a_ref_keys: assert property (@(posedge core_clk_i) disable iff (rst_i)
		ref_q |=> !cap_q && !comp_q && view_q == S_MEASURE)
		else $error("key accepted in reference mode");

endmodule

// file: meter_panel_partner.sv
// Front-panel key and measured-level source facing the panel control
`timescale 1ns/10ps
module meter_panel_partner
(
	// Clock
	input  wire logic        core_clk_i,
	// Keys and level path
	output meter_pkg::keys_s keys_o,
	output logic [15:0]      level_o,
	output logic [15:0]      full_scale_o,
	output logic [15:0]      overload_o
);
	// Idle keys, range of 1000 counts, overload at 800
	initial
	begin
		keys_o       = '0;
		level_o      = 16'h0000;
		full_scale_o = 16'h03E8;
		overload_o   = 16'h0320;
	end

	// One-cycle key pulse; returns just after the edge that takes it
	task automatic press(input int k);
		@(posedge core_clk_i);
		#2;
		keys_o = 7'h01 << k;
		@(posedge core_clk_i);
		#2;
		keys_o = '0;
	endtask

	// Level moves only off the sampling edge
	task automatic set_level(input logic [15:0] v);
		@(posedge core_clk_i);
		#2;
		level_o = v;
	endtask

	// Range change, also off the sampling edge
	task automatic set_range(input logic [15:0] fs, input logic [15:0] ov);
		@(posedge core_clk_i);
		#2;
		full_scale_o = fs;
		overload_o   = ov;
	endtask
endmodule

// file: test_meter_menu_hold_comparator_ctrl.sv
// Self-checking bench for the front-panel menu, hold and comparator control
`timescale 1ns/10ps
module test_meter_menu_hold_comparator_ctrl;
	// Key bit positions inside keys_s
	localparam int K_MENU = 6, K_UP = 5, K_DOWN = 4, K_REF = 3, K_CAP = 2, K_CLR = 1, K_COMP = 0;
	typedef struct {int code; logic [31:0] val;} note_s;
	logic                 core_clk_i, rst_i, servo_input_i, accel_mode_i, nv_valid_i;
	logic                 nv_write_o, menu_shown_o, peak_en_view_o, over_flag_o, blank_o;
	logic                 peak_hold_o, ref_mode_o, capture_o, comp_on_o, alarm_o, buzzer_o;
	logic                 ref_tone_o;
	logic [3:0]           menu_num_o, id0;
	logic [15:0]          level_i, full_scale_i, overload_i, numeric_o, steady_level_output_o;
	logic [15:0]          lv, mx;
	meter_pkg::keys_s     keys_i;
	meter_pkg::settings_s nv_settings_i, nv_settings_o, menu_view_o, settings_o, exp_s;
	note_s                notes[$];
	event                 chk_ev;
	int                   errors, num_checks, seed;

	meter_panel_partner partner_u (.core_clk_i(core_clk_i), .keys_o(keys_i), .level_o(level_i),
		.full_scale_o(full_scale_i), .overload_o(overload_i));

	meter_panel_ctrl dut_u (.core_clk_i(core_clk_i), .rst_i(rst_i), .keys_i(keys_i),
		.level_i(level_i), .full_scale_i(full_scale_i), .overload_i(overload_i),
		.servo_input_i(servo_input_i), .accel_mode_i(accel_mode_i),
		.nv_settings_i(nv_settings_i), .nv_valid_i(nv_valid_i), .nv_settings_o(nv_settings_o),
		.nv_write_o(nv_write_o), .menu_num_o(menu_num_o), .menu_shown_o(menu_shown_o),
		.menu_view_o(menu_view_o), .peak_en_view_o(peak_en_view_o), .numeric_o(numeric_o),
		.over_flag_o(over_flag_o), .blank_o(blank_o), .settings_o(settings_o),
		.peak_hold_o(peak_hold_o), .ref_mode_o(ref_mode_o), .capture_o(capture_o),
		.comp_on_o(comp_on_o), .alarm_o(alarm_o), .buzzer_o(buzzer_o), .ref_tone_o(ref_tone_o),
		.steady_level_output_o(steady_level_output_o));

	// ************************************************************
	// Clock, helpers and result monitor
	// ************************************************************
	initial
	begin
		core_clk_i = 1'b0;
		forever #25 core_clk_i = ~core_clk_i;
	end

	// Observed value for each note code
	function automatic logic [31:0] seen(input int c);
		case (c)
			0: seen = 32'(settings_o);
			1: seen = 32'(menu_num_o);
			2: seen = 32'(menu_shown_o);
			3: seen = 32'(alarm_o);
			4: seen = 32'(buzzer_o);
			5: seen = 32'(comp_on_o);
			6: seen = 32'(capture_o);
			7: seen = 32'(ref_mode_o);
			8: seen = 32'(peak_hold_o);
			9: seen = 32'(numeric_o);
			10: seen = 32'(steady_level_output_o);
			11: seen = 32'(nv_write_o);
			12: seen = 32'(over_flag_o);
			13: seen = 32'(menu_view_o);
			15: seen = 32'(ref_tone_o);
			16: seen = 32'(blank_o);
			17: seen = 32'(peak_en_view_o);
			default: seen = 32'(nv_settings_o);
		endcase
	endfunction

	task automatic expect_val(input int c, input logic [31:0] v);
		notes.push_back('{c, v});
		->chk_ev;
	endtask

	// Let n edges land, then sample settled outputs
	task automatic step(input int n);
		repeat (n) @(posedge core_clk_i);
		#2;
	endtask

	task automatic menu_n(input int n);
		repeat (n) partner_u.press(K_MENU);
	endtask

	task automatic tally_and_finish;
		$display("Checks: %0d, errors: %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// Drains every queued note, oldest first, whenever results are posted
	initial
	begin
		note_s n;
		static string nm [18] = '{"settings_o", "menu_num_o", "menu_shown_o", "alarm_o",
			"buzzer_o", "comp_on_o", "capture_o", "ref_mode_o", "peak_hold_o", "numeric_o",
			"steady_level_output_o", "nv_write_o", "over_flag_o", "menu_view_o", "nv_settings_o",
			"ref_tone_o", "blank_o", "peak_en_view_o"};
		forever
		begin
			@(chk_ev);
			while (notes.size() > 0)
			begin
				n = notes.pop_front();
				num_checks++;
				if (seen(n.code) !== n.val)
				begin
					errors++;
					$display("[ERR] %s expected %h seen %h", nm[n.code], n.val, seen(n.code));
				end
			end
		end
	end

	// Watchdog: the whole sequence needs well under 10000 cycles
	initial
	begin
		#3000000;
		errors++;
		tally_and_finish();
	end

	// ************************************************************
	// Main sequence
	// ************************************************************
	initial
	begin
		seed = 86;
		rst_i = 1'b1;
		servo_input_i = 1'b0;
		accel_mode_i = 1'b0;
		nv_valid_i = 1'b0;
		id0 = 4'($unsigned($random(seed)) % 15);
		nv_settings_i = '{meter_pkg::PORT_OFF, meter_pkg::RATE_9600, id0, 7'h10, 4'h0, 1'b0,
			7'h00, 1'b0};
		repeat (16) @(posedge core_clk_i);
		#2;
		rst_i = 1'b0;
		step(1);
		expect_val(0, 32'(meter_pkg::SETTINGS_RST));
		nv_valid_i = 1'b1;
		step(1);
		expect_val(0, 32'(nv_settings_i));
		// Menu walk with edits on pages 0 to 4, 6 and 8; peak hold without accel stays off
		exp_s = nv_settings_i;
		exp_s.port_mode = meter_pkg::PORT_SERIAL;
		exp_s.rate = meter_pkg::RATE_19200;
		exp_s.station_id = id0 + 4'h1;
		exp_s.thr_pct = 7'h12;
		exp_s.auto_clr = 1'b1;
		exp_s.buzz_en = 1'b1;
		for (int i = 0; i <= 9; i++)
		begin
			partner_u.press(K_MENU);
			expect_val(2, 32'(i < 9));
			if (i < 9)
				expect_val(1, 32'(i));
			if (i inside {0, 1, 2, 3, 4, 6, 8})
				partner_u.press(K_UP);
			if (i == 0)
			begin
				partner_u.press(K_UP);
				expect_val(13, 32'({meter_pkg::PORT_PRINTER, nv_settings_i[25:0]}));
				partner_u.press(K_DOWN);
			end
			if (i == 8)
			begin
				expect_val(13, 32'(exp_s));
				expect_val(17, 1);
				expect_val(0, 32'(nv_settings_i));
			end
		end
		expect_val(0, 32'(exp_s));
		expect_val(11, 1);
		expect_val(14, 32'(exp_s));
		expect_val(8, 0);
		step(1);
		expect_val(11, 0);
		// Comparator with zero delay, auto clear after zero seconds, buzzer on
		partner_u.press(K_COMP);
		expect_val(5, 1);
		partner_u.press(K_MENU);
		expect_val(2, 0);
		partner_u.set_level(16'h0100);
		step(2);
		expect_val(3, 1);
		expect_val(4, 1);
		expect_val(16, 0);
		partner_u.press(K_CLR);
		expect_val(3, 0);
		expect_val(5, 1);
		step(2);
		expect_val(3, 1);
		partner_u.set_level(16'h0040);
		step(5);
		expect_val(3, 0);
		expect_val(4, 0);
		partner_u.set_level(16'h0100);
		step(2);
		partner_u.press(K_COMP);
		expect_val(5, 0);
		expect_val(3, 0);
		// Largest value capture on random levels
		partner_u.set_level(16'h0000);
		partner_u.press(K_CAP);
		expect_val(6, 1);
		partner_u.press(K_MENU);
		expect_val(2, 0);
		partner_u.press(K_REF);
		expect_val(7, 0);
		mx = 16'h0000;
		for (int j = 0; j < 6; j++)
		begin
			lv = 16'($random(seed)) & 16'h01FF;
			partner_u.set_level(lv);
			if (lv > mx)
				mx = lv;
			step(2);
			expect_val(9, 32'(mx));
		end
		partner_u.set_level(16'h0384);
		step(2);
		expect_val(12, 1);
		partner_u.set_level(16'h0020);
		partner_u.press(K_CLR);
		step(2);
		expect_val(9, 32'h0020);
		expect_val(12, 0);
		partner_u.press(K_CAP);
		expect_val(6, 0);
		// Reference signal mode on a new random range, servo tone still in its first half
		lv = 16'($random(seed)) | 16'h0400;
		servo_input_i = 1'b1;
		partner_u.set_range(lv, 16'h0100);
		partner_u.press(K_REF);
		expect_val(7, 1);
		step(2);
		expect_val(10, 32'(lv));
		expect_val(15, 0);
		partner_u.press(K_MENU);
		expect_val(2, 0);
		partner_u.press(K_COMP);
		expect_val(5, 0);
		partner_u.press(K_REF);
		expect_val(7, 0);
		step(2);
		expect_val(10, 32'h0020);
		// Peak hold through menu 3; samples land every 390 cycles
		accel_mode_i = 1'b1;
		menu_n(4);
		partner_u.press(K_UP);
		menu_n(6);
		expect_val(8, 1);
		partner_u.press(K_CAP);
		expect_val(6, 0);
		partner_u.set_level(16'h0200);
		step(800);
		expect_val(9, 32'h0200);
		expect_val(12, 1);
		partner_u.set_level(16'h0050);
		step(800);
		expect_val(9, 32'h0200);
		partner_u.press(K_CLR);
		step(800);
		expect_val(9, 32'h0050);
		expect_val(12, 0);
		menu_n(4);
		expect_val(1, 3);
		partner_u.press(K_DOWN);
		menu_n(6);
		expect_val(8, 0);
		step(2);
		tally_and_finish();
	end
endmodule
